// [rtl/tcc_axi.sv]
// AXI4-Lite slave turning bus cycles into byte strobes
`timescale 1ns/1ps
module tcc_axi import tcc_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Write address and data
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core side
  output tcc_req_t req,
  input wire logic [7:0] rd_byte
);
  // Latched halves of a write
  logic aw_have;
  logic w_have;
  tcc_rd_state_t rd_state;
  // Request fields, each owned by one process, packed into req
  logic wr_q;
  logic wstrb_q;
  logic [AW-1:0] waddr_q;
  logic [7:0] wdata_q;
  logic rd_q;
  logic [AW-1:0] raddr_q;
  assign req = {wr_q, wstrb_q, waddr_q, wdata_q, rd_q, raddr_q};
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  // Both halves present and no answer owed
  wire wr_go = aw_have & w_have & ~s_axi_bvalid;
  wire next_aw = (aw_have | aw_hs) & ~wr_go;
  wire next_w = (w_have | w_hs) & ~wr_go;
  // Write side: address and data in either order
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OK;
      wr_q <= 1'b0;
      wstrb_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= BYTE0;
    end else begin
      aw_have <= next_aw;
      w_have <= next_w;
      s_axi_awready <= ~next_aw;
      s_axi_wready <= ~next_w;
      wr_q <= wr_go;
      if (aw_hs) begin
        waddr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_q <= s_axi_wdata[7:0];
        wstrb_q <= s_axi_wstrb[0];
      end
      // Unmapped offsets answer with an error
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= tcc_hit(waddr_q) ? RESP_OK : RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Read side: take, fetch one cycle, answer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_state <= TCC_RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OK;
      rd_q <= 1'b0;
      raddr_q <= '0;
    end else begin
      case (rd_state)
        TCC_RD_IDLE: begin
          s_axi_arready <= 1'b1;
          if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            raddr_q <= s_axi_araddr;
            rd_q <= 1'b1;
            rd_state <= TCC_RD_FETCH;
          end
        end
        TCC_RD_FETCH: begin
          rd_q <= 1'b0;
          s_axi_rvalid <= 1'b1;
          s_axi_rdata <= {24'h000000, rd_byte};
          s_axi_rresp <= tcc_hit(raddr_q) ? RESP_OK : RESP_ERR;
          rd_state <= TCC_RD_RESP;
        end
        TCC_RD_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_state <= TCC_RD_IDLE;
          end
        end
        default: begin
          rd_state <= TCC_RD_IDLE;
        end
      endcase
    end
  end
endmodule

// [rtl/tcc_core.sv]
// Timer capture, compare, forced compare and one-pulse logic
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - Active edge latches counter, sets capture flag
// - Edge select bits pick each pin's edge
// - One capture interrupt enable covers both capture flags
// - Blocked capture requests are dropped, not held pending
// - Capture flag clears: status read, low access
// - High read blocks capture until low read
// - Newest capture overwrites the capture value
// - Pins always feed capture, even as outputs
// - Special modes leave only capture two usable
// - Compare values compared each tick, reset 8000h
// - Match sets flag, drives level, may interrupt
// - Compare pin latches low during reset
// - Output disabled: no level, flag still sets
// - Compare flag clears: status read, low access
// - High write suspends compare until low write
// - Divide-by-2 matches equal, others equal plus one
// - Force copies level, no flag, no interrupt
// - Force ignored in one-pulse or pulse-width mode
// - Mode bit selects one-pulse, uses channel one
// - One-pulse trigger: reset counter, level two, FFFDh
// - One-pulse compare one match drives level one
// - Capture values are read-only to software
// - One-pulse: compare flag one never sets
module tcc_core import tcc_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // AXI4-Lite register port
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Rest of the timer
  input wire logic [15:0] counter,
  input wire logic timer_tick,
  input wire logic cpu_irq_mask,
  output logic counter_reset_req,
  output logic timer_irq,
  // Pins
  input wire logic [1:0] capture_pin,
  output logic [1:0] compare_pin,
  output logic [1:0] compare_drive
);
  // ********************************
  // Reset release
  // ********************************
  logic rst_q;
  logic rst_n;
  // Release through two flops
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q <= 1'b1;
      rst_n <= rst_q;
    end
  end

  // ********************************
  // Bus slave and pin synchroniser
  // ********************************
  tcc_req_t req;
  logic [7:0] rd_byte;
  logic [1:0] pin_sync;
  tcc_axi u_axi (
    .clock(clock),
    .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .req(req),
    .rd_byte(rd_byte)
  );
  // Pins are async to the clock
  tcc_sync #(.W(2)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(capture_pin),
    .sync_out(pin_sync)
  );

  // ********************************
  // State
  // ********************************
  logic [7:0] ctl1; // Control one, force bits read 0
  logic [7:0] ctl2; // Control two
  logic [15:0] cap_val [2]; // Capture values
  logic [15:0] cmp_val [2]; // Compare values
  logic [1:0] cap_flag; // Capture flags
  logic [1:0] cmp_flag; // Compare flags
  logic [1:0] cap_arm; // Status seen with flag set
  logic [1:0] cmp_arm;
  logic [1:0] cap_lock; // High byte read, low pending
  logic [1:0] cmp_susp; // High byte written
  logic [1:0] pin_prev; // Last synced pin level

  // ********************************
  // Bus decode
  // ********************************
  wire wr = req.wr & req.wstrb0;
  wire rd = req.rd;
  wire [AW-1:0] wa = req.waddr;
  wire [AW-1:0] ra = req.raddr;
  wire [7:0] wd = req.wdata;
  wire wr_ctl1 = wr & (wa == ADR_CTL1);
  wire wr_ctl2 = wr & (wa == ADR_CTL2);
  wire rd_stat = rd & (ra == ADR_STAT);
  wire [1:0] wr_cmph;
  wire [1:0] wr_cmpl;
  wire [1:0] rd_caph;
  wire [1:0] acc_capl;
  wire [1:0] acc_cmpl;
  assign wr_cmph = {wr & (wa == ADR_CMP2H), wr & (wa == ADR_CMP1H)};
  assign wr_cmpl = {wr & (wa == ADR_CMP2L), wr & (wa == ADR_CMP1L)};
  assign rd_caph = {rd & (ra == ADR_CAP2H), rd & (ra == ADR_CAP1H)};
  // Low byte access: a read or a write both count
  assign acc_capl = {
    (wr & (wa == ADR_CAP2L)) | (rd & (ra == ADR_CAP2L)),
    (wr & (wa == ADR_CAP1L)) | (rd & (ra == ADR_CAP1L))};
  assign acc_cmpl = {
    (wr & (wa == ADR_CMP2L)) | (rd & (ra == ADR_CMP2L)),
    (wr & (wa == ADR_CMP1L)) | (rd & (ra == ADR_CMP1L))};

  // Read data selection, unmapped reads zero
  assign rd_byte =
    (ra == ADR_CTL1) ? ctl1 :
    (ra == ADR_CTL2) ? ctl2 :
    (ra == ADR_STAT) ? {4'h0, cmp_flag, cap_flag} :
    (ra == ADR_CAP1H) ? cap_val[0][15:8] :
    (ra == ADR_CAP1L) ? cap_val[0][7:0] :
    (ra == ADR_CAP2H) ? cap_val[1][15:8] :
    (ra == ADR_CAP2L) ? cap_val[1][7:0] :
    (ra == ADR_CMP1H) ? cmp_val[0][15:8] :
    (ra == ADR_CMP1L) ? cmp_val[0][7:0] :
    (ra == ADR_CMP2H) ? cmp_val[1][15:8] :
    (ra == ADR_CMP2L) ? cmp_val[1][7:0] : BYTE0;

  // ********************************
  // Modes and events
  // ********************************
  // Pulse-width mode wins when both are set
  wire pwm = ctl2[B_PWM];
  wire single_pulse_select = ctl2[B_OPM] & ~pwm;
  wire [1:0] clk_sel = ctl2[B_CLK+1:B_CLK];
  wire [1:0] oe = {ctl2[B_OE2], ctl2[B_OE1]};
  wire lvl1 = ctl1[B_LVL1];
  wire lvl2 = ctl1[B_LVL2];
  wire [1:0] edge_sel = {ctl2[B_EDGE2], ctl1[B_EDGE1]};
  // Edge select 1 means rising, 0 falling
  wire [1:0] rise = pin_sync & ~pin_prev;
  wire [1:0] fall = ~pin_sync & pin_prev;
  // Only the selected edge counts, whatever the pin's use
  wire [1:0] cap_ev = (edge_sel & rise) | (~edge_sel & fall);
  // Capture one is the trigger in one-pulse mode
  wire opm_trig = cap_ev[0] & single_pulse_select;
  // Capture one is cut off in pulse-width mode
  wire [1:0] cap_set = cap_ev & {1'b1, ~pwm} & ~cap_lock;
  // One-pulse capture loads a fixed value
  wire [15:0] cap_load0 = single_pulse_select ? OPM_CAPTURE : counter;

  // Slow clocks match one count after equality
  function automatic logic [15:0] cmp_target(
    input logic [15:0] v,
    input logic [1:0] sel);
    cmp_target = (sel == CLK_DIV2) ? v : 16'(v + ONE16);
  endfunction
  wire [1:0] match;
  assign match[0] = timer_tick & ~cmp_susp[0]
    & (counter == cmp_target(cmp_val[0], clk_sel));
  assign match[1] = timer_tick & ~cmp_susp[1]
    & (counter == cmp_target(cmp_val[1], clk_sel));
  // Flag one is held off in one-pulse mode
  wire [1:0] cmp_set = match & {~pwm, ~pwm & ~single_pulse_select};
  // Force pulses are ignored in special modes
  wire [1:0] force_ev = {2{wr_ctl1 & ~single_pulse_select & ~pwm}}
    & {wd[B_FRC2], wd[B_FRC1]} & oe;

  // ********************************
  // Control registers
  // ********************************
  // Force bits are strobes, never stored
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctl1 <= BYTE0;
      ctl2 <= BYTE0;
    end else begin
      if (wr_ctl1) begin
        ctl1 <= wd & ~FORCE_MASK;
      end
      if (wr_ctl2) begin
        ctl2 <= wd;
      end
    end
  end

  // ********************************
  // Capture channels
  // ********************************
  // Set wins over the two-step clear
  wire [1:0] cap_clr = cap_arm & acc_capl;
  wire [1:0] next_cap_flag = cap_set | (cap_flag & ~cap_clr);
  // Status read arms only flags that are set
  wire [1:0] next_cap_arm =
    (cap_arm & ~acc_capl) | ({2{rd_stat}} & cap_flag);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cap_flag <= 2'h0;
      cap_arm <= 2'h0;
      cap_lock <= 2'h0;
      pin_prev <= 2'h0;
      cap_val[0] <= 16'h0000;
      cap_val[1] <= 16'h0000;
    end else begin
      pin_prev <= pin_sync;
      cap_flag <= next_cap_flag;
      cap_arm <= next_cap_arm;
      // High read locks, low read unlocks
      cap_lock <= (cap_lock | rd_caph) & ~(acc_capl & {2{rd}});
      // Writes never touch captured values
      if (cap_set[0]) begin
        cap_val[0] <= cap_load0;
      end
      if (cap_set[1]) begin
        cap_val[1] <= counter;
      end
    end
  end

  // ********************************
  // Compare channels
  // ********************************
  wire [1:0] cmp_clr = cmp_arm & acc_cmpl;
  wire [1:0] next_cmp_flag = cmp_set | (cmp_flag & ~cmp_clr);
  wire [1:0] next_cmp_arm =
    (cmp_arm & ~acc_cmpl) | ({2{rd_stat}} & cmp_flag);
  // High write suspends, low write resumes
  wire [1:0] next_susp = (cmp_susp | wr_cmph) & ~wr_cmpl;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmp_flag <= 2'h0;
      cmp_arm <= 2'h0;
      cmp_susp <= 2'h0;
      cmp_val[0] <= CMP_RESET;
      cmp_val[1] <= CMP_RESET;
    end else begin
      cmp_flag <= next_cmp_flag;
      cmp_arm <= next_cmp_arm;
      cmp_susp <= next_susp;
      for (int i = 0; i < 2; i++) begin
        if (wr_cmph[i]) begin
          cmp_val[i][15:8] <= wd;
        end
        if (wr_cmpl[i]) begin
          cmp_val[i][7:0] <= wd;
        end
      end
    end
  end

  // ********************************
  // Pin latches, outputs
  // ********************************
  // Pin one: trigger, end of pulse, match, force
  wire next_pin0 =
    opm_trig ? lvl2 :
    (single_pulse_select & match[0]) ? lvl1 :
    (match[0] & oe[0] & ~pwm) ? lvl1 :
    force_ev[0] ? wd[B_LVL1] : compare_pin[0];
  // Pin two: level two belongs to the pulse in SINGLE_PULSE_SELECT
  // Force takes the level written with it, not the old one
  wire next_pin1 =
    (match[1] & oe[1] & ~single_pulse_select & ~pwm) ? lvl2 :
    force_ev[1] ? wd[B_LVL2] : compare_pin[1];
  // Interrupt stays asserted while a flag waits
  wire next_irq = ~cpu_irq_mask & (
    (ctl1[B_CAPIE] & |cap_flag) |
    (ctl1[B_CMPIE] & |cmp_flag));
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      compare_pin <= 2'h0;
      compare_drive <= 2'h0;
      counter_reset_req <= 1'b0;
      timer_irq <= 1'b0;
    end else begin
      compare_pin <= {next_pin1, next_pin0};
      compare_drive <= oe;
      counter_reset_req <= opm_trig;
      timer_irq <= next_irq;
    end
  end

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  cap_load_a: assert property (
    cap_ev[1] && !cap_lock[1] |=> cap_flag[1]
      && cap_val[1] == $past(counter))
    else $error("capture two missed its load");
  cap_lock_a: assert property (
    cap_lock[0] && !(rd && ra == ADR_CAP1L)
      |=> $stable(cap_val[0]) && !$rose(cap_flag[0]))
    else $error("locked capture changed");
  irq_pend_a: assert property (
    cap_flag[0] && ctl1[B_CAPIE] && !cpu_irq_mask |=> timer_irq)
    else $error("pending capture not raised");
  flag_clear_a: assert property (
    $fell(cap_flag[1]) |-> $past(cap_arm[1] && acc_capl[1]))
    else $error("capture flag fell without clear");
  cmp_hold_a: assert property (
    cmp_susp[0] && !cmp_flag[0] |=> !cmp_flag[0])
    else $error("suspended compare matched");
  opm_fire_a: assert property (
    opm_trig |=> counter_reset_req && cap_flag[0]
      && cap_val[0] == OPM_CAPTURE && compare_pin[0] == $past(lvl2))
    else $error("one-pulse trigger wrong");
  opm_flag_a: assert property (
    single_pulse_select && !cmp_flag[0] |=> !cmp_flag[0])
    else $error("compare flag one set in one-pulse");
  gpio_keep_a: assert property (
    !oe[1] && !single_pulse_select |=> $stable(compare_pin[1]))
    else $error("disabled compare pin moved");
  cmp_val_a: assert property (
    !(wr_cmph[0] || wr_cmpl[0]) |=> $stable(cmp_val[0]))
    else $error("compare value changed alone");
  force_flag_a: assert property (
    force_ev[0] && !match[0] && !cmp_flag[0] |=> !cmp_flag[0])
    else $error("force set a flag");
  cov_cap: cover property (cap_ev[0] ##[1:8] rd_stat);
  cov_opm: cover property (opm_trig ##[1:300] match[0]);
  cov_clr: cover property (cmp_flag[1] ##1 cmp_clr[1]);
endmodule

// [rtl/tcc_pkg.sv]
// Shared constants and types of the timer capture/compare block
package tcc_pkg;
  // ****************
  // Register offsets
  // ****************
  localparam int AW = 6;
  localparam logic [AW-1:0] ADR_CTL1 = 6'h00;
  localparam logic [AW-1:0] ADR_CTL2 = 6'h04;
  localparam logic [AW-1:0] ADR_STAT = 6'h08;
  localparam logic [AW-1:0] ADR_CAP1H = 6'h0C;
  localparam logic [AW-1:0] ADR_CAP1L = 6'h10;
  localparam logic [AW-1:0] ADR_CAP2H = 6'h14;
  localparam logic [AW-1:0] ADR_CAP2L = 6'h18;
  localparam logic [AW-1:0] ADR_CMP1H = 6'h1C;
  localparam logic [AW-1:0] ADR_CMP1L = 6'h20;
  localparam logic [AW-1:0] ADR_CMP2H = 6'h24;
  localparam logic [AW-1:0] ADR_CMP2L = 6'h28;
  // ****************
  // Field positions
  // ****************
  localparam int B_EDGE1 = 0;
  localparam int B_LVL1 = 1;
  localparam int B_LVL2 = 2;
  localparam int B_FRC1 = 3;
  localparam int B_FRC2 = 4;
  localparam int B_CAPIE = 5;
  localparam int B_CMPIE = 6;
  localparam int B_EDGE2 = 0;
  localparam int B_OPM = 1;
  localparam int B_PWM = 2;
  localparam int B_CLK = 3;
  localparam int B_OE1 = 5;
  localparam int B_OE2 = 6;
  // ****************
  // Values
  // ****************
  localparam logic [15:0] CMP_RESET = 16'h8000;
  localparam logic [15:0] OPM_CAPTURE = 16'hFFFD;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [1:0] CLK_DIV2 = 2'h0;
  localparam logic [7:0] BYTE0 = 8'h00;
  localparam logic [7:0] FORCE_MASK = 8'h18;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // Read channel states, one-hot
  typedef enum logic [2:0] {
    TCC_RD_IDLE = 3'b001,
    TCC_RD_FETCH = 3'b010,
    TCC_RD_RESP = 3'b100
  } tcc_rd_state_t;
  // Register access strobes from the bus slave
  typedef struct packed {
    logic wr;
    logic wstrb0;
    logic [AW-1:0] waddr;
    logic [7:0] wdata;
    logic rd;
    logic [AW-1:0] raddr;
  } tcc_req_t;
  // Decoded address is mapped and word aligned
  function automatic logic tcc_hit(input logic [AW-1:0] a);
    tcc_hit = (a[1:0] == 2'h0) && (a <= ADR_CMP2L);
  endfunction
endpackage

// [rtl/tcc_sync.sv]
// Two-flop synchroniser for the capture pins
`timescale 1ns/1ps
module tcc_sync import tcc_pkg::*; #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Async in, synced out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  // First stage, read only by second
  logic [W-1:0] meta;
  // Both stages clear at reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// [test/tb_top.sv]
// Self-checking bench of the capture/compare block
`timescale 1ns/1ps
`define CHK(g, w) begin checked++; if ((g) !== (w)) begin error_cnt++; \
  $display("unexpected at %0t: got %0h want %0h", $time, (g), (w)); end end
module tb_top import tcc_pkg::*;;
  // ****************
  // Signals
  // ****************
  logic clock = 1'h0;
  logic rst_b = 1'h0;
  logic [AW-1:0] s_axi_awaddr = 6'h00;
  logic [AW-1:0] s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata;
  logic [15:0] counter = 16'h0000;
  logic timer_tick = 1'h0, cpu_irq_mask = 1'h1;
  logic counter_reset_req, timer_irq;
  logic [1:0] capture_pin, compare_pin, compare_drive, load_level;
  logic [7:0] rv;
  int error_cnt = 0, checked = 0, nreq = 0, n0;
  tcc_core i_dut (.clock, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .counter, .timer_tick,
    .cpu_irq_mask, .counter_reset_req, .timer_irq, .capture_pin,
    .compare_pin, .compare_drive);
  tcc_src i_src (.clock, .compare_pin, .compare_drive, .capture_pin,
    .load_level);
  // 50 MHz clock
  initial begin
    forever #10 clock = ~clock;
  end
  // Counts one-cycle counter reload requests
  always @(posedge clock) if (counter_reset_req === 1'h1) nreq++;
  // ****************
  // Bus and helpers
  // ****************
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic hang();
    error_cnt++;
    $display("unexpected at %0t: no answer", $time);
    print_verdict();
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clock);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      n++;
    end while (s_axi_bvalid !== 1'h1 && n < 40);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    if (n >= 40) hang();
  endtask
  task automatic rd(input logic [AW-1:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clock);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      n++;
    end while (s_axi_rvalid !== 1'h1 && n < 40);
    d = s_axi_rdata[7:0];
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    if (n >= 40) hang();
  endtask
  // Pin move, then room for sync, detect and load
  task automatic pin(input int i, input logic v);
    i_src.set_pin(i, v);
    repeat (6) @(posedge clock);
  endtask
  // One timer count at a given counter value
  task automatic tick(input logic [15:0] v);
    @(posedge clock);
    counter <= v;
    timer_tick <= 1'h1;
    @(posedge clock);
    timer_tick <= 1'h0;
    repeat (3) @(posedge clock);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic s_reset();
    rd(ADR_CMP1H, rv);
    `CHK(rv, 8'h80)
    rd(ADR_CMP2L, rv);
    `CHK(rv, 8'h00)
    rd(6'h2C, rv);
    `CHK(resp, RESP_ERR)
    wr(6'h2C, 8'h00);
    `CHK(resp, RESP_ERR)
  endtask
  // Pin 1 rising capture, pending interrupt, two-step clear
  task automatic s_capture();
    wr(ADR_CTL1, 8'h21);
    `CHK(resp, RESP_OK)
    counter <= 16'h1234;
    pin(0, 1'h1);
    `CHK(timer_irq, 1'h0)
    cpu_irq_mask <= 1'h0;
    repeat (3) @(posedge clock);
    `CHK(timer_irq, 1'h1)
    rd(ADR_STAT, rv);
    `CHK(rv[0], 1'h1)
    wr(ADR_CAP1H, 8'hAA);
    rd(ADR_CAP1H, rv);
    `CHK(rv, 8'h12)
    rd(ADR_CAP1L, rv);
    `CHK(rv, 8'h34)
    pin(0, 1'h0);
    rd(ADR_STAT, rv);
    `CHK(rv[0], 1'h0)
  endtask
  // Pin 2 falling edge, capture lock, newest value wins
  task automatic s_lock();
    wr(ADR_CTL2, 8'h00);
    pin(1, 1'h1);
    rd(ADR_STAT, rv);
    `CHK(rv[1], 1'h0)
    rd(ADR_CAP2H, rv);
    pin(1, 1'h0);
    rd(ADR_STAT, rv);
    `CHK(rv[1], 1'h0)
    rd(ADR_CAP2L, rv);
    counter <= 16'h5678;
    pin(1, 1'h1);
    pin(1, 1'h0);
    counter <= 16'h9ABC;
    pin(1, 1'h1);
    pin(1, 1'h0);
    `CHK(timer_irq, 1'h1)
    rd(ADR_STAT, rv);
    `CHK(rv[1], 1'h1)
    rd(ADR_CAP2H, rv);
    `CHK(rv, 8'h9A)
    rd(ADR_CAP2L, rv);
    `CHK(rv, 8'hBC)
    rd(ADR_STAT, rv);
    `CHK(rv[1], 1'h0)
  endtask
  // Match timing per clock select, suspend, disabled output
  task automatic s_compare();
    wr(ADR_CTL1, 8'h42);
    wr(ADR_CTL2, 8'h20);
    wr(ADR_CMP1H, 8'h40);
    rd(ADR_STAT, rv);
    wr(ADR_CMP1L, 8'h10);
    tick(16'h4010);
    `CHK(load_level[0], 1'h1)
    `CHK(timer_irq, 1'h1)
    rd(ADR_STAT, rv);
    `CHK(rv[2], 1'h1)
    wr(ADR_CMP1L, 8'h10);
    rd(ADR_STAT, rv);
    `CHK(rv[2], 1'h0)
    wr(ADR_CTL2, 8'h28);
    wr(ADR_CTL1, 8'h40);
    tick(16'h4010);
    `CHK(load_level[0], 1'h1)
    tick(16'h4011);
    `CHK(load_level[0], 1'h0)
    wr(ADR_CMP1H, 8'h40);
    wr(ADR_CTL1, 8'h46);
    tick(16'h4011);
    `CHK(load_level[0], 1'h0)
    wr(ADR_CMP1L, 8'h10);
    tick(16'h4011);
    `CHK(load_level[0], 1'h1)
    tick(16'h8001);
    `CHK({compare_drive[1], compare_pin[1], load_level[1]}, 3'h0)
    rd(ADR_STAT, rv);
    `CHK(rv[3], 1'h1)
    wr(ADR_CMP1L, 8'h10);
    wr(ADR_CMP2L, 8'h00);
  endtask
  // Forced level, then ignored in one-pulse mode
  task automatic s_force();
    wr(ADR_CTL1, 8'h48);
    repeat (2) @(posedge clock);
    `CHK(load_level[0], 1'h0)
    `CHK(timer_irq, 1'h0)
    rd(ADR_STAT, rv);
    `CHK(rv[3:2], 2'h0)
    wr(ADR_CTL2, 8'h22);
    wr(ADR_CTL1, 8'h4A);
    repeat (2) @(posedge clock);
    `CHK(load_level[0], 1'h0)
  endtask
  // Trigger on pin 1, pulse ends at compare one
  task automatic s_opm();
    wr(ADR_CTL1, 8'h65);
    n0 = nreq;
    pin(0, 1'h1);
    `CHK(nreq - n0, 1)
    `CHK(load_level[0], 1'h1)
    rd(ADR_STAT, rv);
    `CHK(rv[0], 1'h1)
    rd(ADR_CAP1H, rv);
    `CHK(rv, 8'hFF)
    rd(ADR_CAP1L, rv);
    `CHK(rv, 8'hFD)
    tick(16'h4010);
    `CHK(load_level[0], 1'h0)
    rd(ADR_STAT, rv);
    `CHK(rv[2], 1'h0)
    wr(ADR_CTL2, 8'h04);
    pin(0, 1'h0);
    pin(0, 1'h1);
    rd(ADR_STAT, rv);
    `CHK(rv[0], 1'h0)
  endtask
  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (5) @(posedge clock);
    `CHK(compare_pin, 2'h0)
    repeat (7) @(posedge clock);
    rst_b <= 1'h1;
    repeat (4) @(posedge clock);
    s_reset();
    s_capture();
    s_lock();
    s_compare();
    s_force();
    s_opm();
    print_verdict();
  end
  // Cuts a stuck run short
  initial begin
    repeat (20000) @(posedge clock);
    hang();
  end
endmodule

// [test/tcc_src.sv]
// Capture signal sources and compare pin loads
`timescale 1ns/1ps
module tcc_src import tcc_pkg::*; (
  // Clock
  input wire logic clock,
  // Compare pins from the block
  input wire logic [1:0] compare_pin,
  input wire logic [1:0] compare_drive,
  // Capture pins to the block
  output logic [1:0] capture_pin,
  // Level seen at each load
  output logic [1:0] load_level
);
  // Pull-down load: an undriven compare pin reads low, never the last value
  assign load_level = compare_pin & compare_drive;
  // Sources idle low
  initial capture_pin = 2'h0;
  // Move one source line just after an edge; it then holds
  task automatic set_pin(input int i, input logic v);
    @(posedge clock);
    capture_pin[i] <= v;
  endtask
endmodule
